// file: hdl/sleep_pkg.sv
`default_nettype none
package sleep_pkg;

  // ----------------------------------------
  // Configuration selectors
  // ----------------------------------------
  localparam logic [2:0] SEL_SLEEP_MODE = 3'h0;
  localparam logic [2:0] SEL_WAKE_TIME = 3'h1;
  localparam logic [2:0] SEL_CYCLIC_PERIOD = 3'h2;
  localparam logic [2:0] SEL_UNJOINED_PERIOD = 3'h3;
  localparam logic [2:0] SEL_SLEEP_OPTIONS = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;

  // ----------------------------------------
  // Sleep mode encodings
  // ----------------------------------------
  localparam logic [7:0] MODE_NO_SLEEP = 8'h00;
  localparam logic [7:0] MODE_PIN_SLEEP = 8'h01;
  localparam logic [7:0] MODE_CYCLIC = 8'h04;
  localparam logic [7:0] MODE_CYCLIC_PIN = 8'h05;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [7:0] SLEEP_MODE_RST = 8'h00;
  localparam logic [15:0] WAKE_TIME_RST = 16'h1388;
  localparam logic [15:0] WAKE_TIME_MIN = 16'h0001;
  localparam logic [15:0] CYCLIC_PERIOD_RST = 16'h0000;
  localparam logic [15:0] UNJOINED_PERIOD_RST = 16'h03e8;
  localparam logic [15:0] UNJOINED_PERIOD_MIN = 16'h0001;
  localparam logic [15:0] PERIOD_MAX = 16'h68b0;
  localparam logic [1:0] SLEEP_OPTIONS_RST = 2'h0;
  localparam logic [15:0] SLEEP_OPTIONS_MAX = 16'h0003;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPT_NO_WAKE_POLL_BIT = 0;
  localparam int OPT_NO_WAKE_SAMPLE_BIT = 1;
  localparam int STAT_ASLEEP_BIT = 0;
  localparam int STAT_UNJOINED_BIT = 1;
  localparam int STAT_MSG_HELD_BIT = 2;
  localparam int STAT_DIRECT_BIT = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PERIOD_UNIT_MS = 10;
  // Hold time is 2.5 period units, i.e. 25 ms per unit
  localparam int HOLD_MS_PER_UNIT = (PERIOD_UNIT_MS * 5) / 2;

endpackage
`default_nettype wire

// file: hdl/tick_gen.sv
`default_nettype none
module tick_gen #(
  parameter int PERIOD = 25000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Tick
  output logic tick_out
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == 32'(PERIOD - 1));
  assign cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= wrap;
    end
  end

endmodule
`default_nettype wire

// file: hdl/pin_sync.sv
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pin and clean level
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Level changes only once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// file: hdl/cyclic_sleep_controller.sv
`default_nettype none
module cyclic_sleep_controller
  import sleep_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Configuration commands
  input wire logic cfg_wr_in,
  input wire logic [2:0] cfg_sel_in,
  input wire logic [15:0] cfg_wdata_in,
  output logic [15:0] cfg_rdata_out,
  output logic cfg_err_out,
  // Role and network state
  input wire logic is_coordinator_in,
  input wire logic associate_en_in,
  input wire logic associated_in,
  input wire logic activity_in,
  // Sleep control pin
  input wire logic sleep_pin_in,
  // Indirect message slot
  input wire logic msg_store_in,
  input wire logic msg_delivered_in,
  output logic msg_held_out,
  output logic msg_discard_out,
  output logic direct_mode_out,
  // Sleep status and wake actions
  output logic asleep_out,
  output logic poll_req_out,
  output logic assoc_retry_out,
  output logic sample_req_out
);

  typedef enum logic {ST_AWAKE, ST_SLEEP} state_e;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic mode_valid(input logic [15:0] v);
    mode_valid = (v == 16'(MODE_NO_SLEEP)) || (v == 16'(MODE_PIN_SLEEP)) ||
                 (v == 16'(MODE_CYCLIC)) || (v == 16'(MODE_CYCLIC_PIN));
  endfunction

  // ----------------------------------------
  // Tick source and pin
  // ----------------------------------------
  logic ms_tick;
  logic pin_lvl;

  tick_gen #(
    .PERIOD(MS_TICK_CYCLES)
  ) u_ms_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(ms_tick)
  );

  pin_sync u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(sleep_pin_in),
    .level_out(pin_lvl)
  );

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] sleep_mode_select_q;
  logic [15:0] wake_time_ms_q;
  logic [15:0] cyclic_sleep_period_q;
  logic [15:0] unjoined_sleep_period_q;
  logic [1:0] sleep_options_q;

  wire wr_mode = cfg_wr_in && (cfg_sel_in == SEL_SLEEP_MODE);
  wire wr_wake = cfg_wr_in && (cfg_sel_in == SEL_WAKE_TIME);
  wire wr_cyc = cfg_wr_in && (cfg_sel_in == SEL_CYCLIC_PERIOD);
  wire wr_unj = cfg_wr_in && (cfg_sel_in == SEL_UNJOINED_PERIOD);
  wire wr_opt = cfg_wr_in && (cfg_sel_in == SEL_SLEEP_OPTIONS);

  wire ok_mode = mode_valid(cfg_wdata_in);
  wire ok_wake = in_range(cfg_wdata_in, WAKE_TIME_MIN, 16'hffff);
  wire ok_cyc = in_range(cfg_wdata_in, 16'h0000, PERIOD_MAX);
  wire ok_unj = in_range(cfg_wdata_in, UNJOINED_PERIOD_MIN, PERIOD_MAX);
  wire ok_opt = in_range(cfg_wdata_in, 16'h0000, SLEEP_OPTIONS_MAX);

  wire wr_err = (wr_mode && !ok_mode) || (wr_wake && !ok_wake) || (wr_cyc && !ok_cyc) ||
                (wr_unj && !ok_unj) || (wr_opt && !ok_opt) ||
                (cfg_wr_in && (cfg_sel_in > SEL_SLEEP_OPTIONS));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_mode_select_q <= SLEEP_MODE_RST;
      wake_time_ms_q <= WAKE_TIME_RST;
      cyclic_sleep_period_q <= CYCLIC_PERIOD_RST;
      unjoined_sleep_period_q <= UNJOINED_PERIOD_RST;
      sleep_options_q <= SLEEP_OPTIONS_RST;
    end else begin
      if (wr_mode && ok_mode) begin
        sleep_mode_select_q <= cfg_wdata_in[7:0];
      end
      if (wr_wake && ok_wake) begin
        wake_time_ms_q <= cfg_wdata_in;
      end
      if (wr_cyc && ok_cyc) begin
        cyclic_sleep_period_q <= cfg_wdata_in;
      end
      if (wr_unj && ok_unj) begin
        unjoined_sleep_period_q <= cfg_wdata_in;
      end
      if (wr_opt && ok_opt) begin
        sleep_options_q <= cfg_wdata_in[1:0];
      end
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire cyclic = (sleep_mode_select_q == MODE_CYCLIC) || (sleep_mode_select_q == MODE_CYCLIC_PIN);
  wire pin_wake_mode = (sleep_mode_select_q == MODE_CYCLIC_PIN);
  wire pin_mode = (sleep_mode_select_q == MODE_PIN_SLEEP);
  wire cyc_end_dev = cyclic && !is_coordinator_in;
  wire unjoined = associate_en_in && !associated_in;
  wire direct = (cyclic_sleep_period_q == 16'h0000);

  // ----------------------------------------
  // Sleep state machine
  // ----------------------------------------
  state_e state_q;
  state_e state_d;
  logic [15:0] wake_ms_q;
  logic [15:0] wake_ms_d;
  logic [15:0] sleep_left_q;
  logic [15:0] sleep_left_d;
  logic [3:0] sub_ms_q;
  logic [3:0] sub_ms_d;
  logic slept_unjoined_q;
  logic slept_unjoined_d;
  logic pin_lvl_q;

  wire pin_rise = pin_lvl && !pin_lvl_q;
  wire unit_tick = ms_tick && (sub_ms_q == 4'(PERIOD_UNIT_MS - 1));
  wire wake_done = ms_tick && (wake_ms_q >= wake_time_ms_q - 16'h0001);
  wire early_wake = pin_wake_mode && pin_rise;
  wire period_done = (sleep_left_q == 16'h0000);
  wire wake_event = (state_q == ST_SLEEP) && cyc_end_dev && (early_wake || period_done);
  wire [15:0] period_pick = unjoined ? unjoined_sleep_period_q : cyclic_sleep_period_q;

  always_comb begin
    state_d = state_q;
    wake_ms_d = wake_ms_q;
    sleep_left_d = sleep_left_q;
    sub_ms_d = sub_ms_q;
    slept_unjoined_d = slept_unjoined_q;
    unique case (state_q)
      ST_AWAKE: begin
        if (!cyc_end_dev || activity_in) begin
          wake_ms_d = 16'h0000;
        end else if (wake_done) begin
          state_d = ST_SLEEP;
          sleep_left_d = period_pick;
          sub_ms_d = 4'h0;
          slept_unjoined_d = unjoined;
          wake_ms_d = 16'h0000;
        end else if (ms_tick) begin
          wake_ms_d = wake_ms_q + 16'h0001;
        end
      end
      ST_SLEEP: begin
        if (!cyc_end_dev || wake_event) begin
          state_d = ST_AWAKE;
          wake_ms_d = 16'h0000;
        end else if (ms_tick) begin
          sub_ms_d = unit_tick ? 4'h0 : sub_ms_q + 4'h1;
          if (unit_tick) begin
            sleep_left_d = sleep_left_q - 16'h0001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_AWAKE;
      wake_ms_q <= 16'h0000;
      sleep_left_q <= 16'h0000;
      sub_ms_q <= 4'h0;
      slept_unjoined_q <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_ms_q <= wake_ms_d;
      sleep_left_q <= sleep_left_d;
      sub_ms_q <= sub_ms_d;
      slept_unjoined_q <= slept_unjoined_d;
      pin_lvl_q <= pin_lvl;
    end
  end

  // ----------------------------------------
  // Wake actions and sleep status
  // ----------------------------------------
  wire poll_now = wake_event && !slept_unjoined_q && !sleep_options_q[OPT_NO_WAKE_POLL_BIT];
  wire retry_now = wake_event && slept_unjoined_q;
  wire sample_now = wake_event && !sleep_options_q[OPT_NO_WAKE_SAMPLE_BIT];
  wire asleep_d = (state_d == ST_SLEEP) || (pin_mode && !is_coordinator_in && pin_lvl);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      poll_req_out <= 1'b0;
      assoc_retry_out <= 1'b0;
      sample_req_out <= 1'b0;
      asleep_out <= 1'b0;
    end else begin
      poll_req_out <= poll_now;
      assoc_retry_out <= retry_now;
      sample_req_out <= sample_now;
      asleep_out <= asleep_d;
    end
  end

  // ----------------------------------------
  // Indirect message hold on coordinator
  // ----------------------------------------
  logic [19:0] hold_ms_q;
  wire [19:0] hold_limit = 20'(cyclic_sleep_period_q) * 20'(HOLD_MS_PER_UNIT);
  wire hold_active = is_coordinator_in && !direct;
  wire hold_expire = msg_held_out && ms_tick && (hold_ms_q >= hold_limit - 20'h00001);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msg_held_out <= 1'b0;
      msg_discard_out <= 1'b0;
      hold_ms_q <= 20'h00000;
      direct_mode_out <= 1'b1;
    end else begin
      direct_mode_out <= direct;
      msg_discard_out <= hold_expire || (msg_held_out && !hold_active);
      if (msg_store_in && hold_active) begin
        msg_held_out <= 1'b1;
        hold_ms_q <= 20'h00000;
      end else if (msg_delivered_in || hold_expire || !hold_active) begin
        msg_held_out <= 1'b0;
        hold_ms_q <= 20'h00000;
      end else if (msg_held_out && ms_tick) begin
        hold_ms_q <= hold_ms_q + 20'h00001;
      end
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  logic [15:0] rdata_d;
  logic [15:0] status_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[STAT_ASLEEP_BIT] = asleep_out;
    status_word[STAT_UNJOINED_BIT] = unjoined;
    status_word[STAT_MSG_HELD_BIT] = msg_held_out;
    status_word[STAT_DIRECT_BIT] = direct;
    unique case (cfg_sel_in)
      SEL_SLEEP_MODE: rdata_d = {8'h00, sleep_mode_select_q};
      SEL_WAKE_TIME: rdata_d = wake_time_ms_q;
      SEL_CYCLIC_PERIOD: rdata_d = cyclic_sleep_period_q;
      SEL_UNJOINED_PERIOD: rdata_d = unjoined_sleep_period_q;
      SEL_SLEEP_OPTIONS: rdata_d = {14'h0000, sleep_options_q};
      SEL_STATUS: rdata_d = status_word;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out <= 16'h0000;
      cfg_err_out <= 1'b0;
    end else begin
      cfg_rdata_out <= rdata_d;
      cfg_err_out <= wr_err;
    end
  end

endmodule
`default_nettype wire

// file: dv/cyclic_sleep_controller_properties.sv
`default_nettype none
module cyclic_sleep_controller_properties (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Configuration
  input wire logic cfg_wr_in,
  input wire logic [2:0] cfg_sel_in,
  input wire logic [15:0] cfg_wdata_in,
  input wire logic cfg_err_out,
  // Role and messages
  input wire logic is_coordinator_in,
  input wire logic msg_store_in,
  input wire logic msg_held_out,
  input wire logic msg_discard_out,
  input wire logic direct_mode_out,
  // Sleep
  input wire logic asleep_out,
  input wire logic poll_req_out,
  input wire logic assoc_retry_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow of accepted settings
  // ----------------------------------------
  logic [7:0] mode_q;
  logic opt_q;
  wire logic wr_mode = cfg_wr_in && cfg_sel_in == 3'h0;
  wire logic mode_ok = cfg_wdata_in inside {16'h0000, 16'h0001, 16'h0004, 16'h0005};
  wire logic wr_cyc = cfg_wr_in && cfg_sel_in == 3'h2;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= 8'h00;
      opt_q <= 1'b0;
    end else begin
      if (wr_mode && mode_ok) mode_q <= cfg_wdata_in[7:0];
      if (cfg_wr_in && cfg_sel_in == 3'h4 && cfg_wdata_in <= 16'h0003) opt_q <= cfg_wdata_in[0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_mode_refuse: assert property (wr_mode && !mode_ok |=> cfg_err_out)
    else $error("bad mode not refused");
  chk_wake_zero: assert property (cfg_wr_in && cfg_sel_in == 3'h1 && cfg_wdata_in == 16'h0000 |=> cfg_err_out)
    else $error("zero wake time not refused");
  chk_wake_accept: assert property (cfg_wr_in && cfg_sel_in == 3'h1 && cfg_wdata_in != 16'h0000 |=> !cfg_err_out)
    else $error("valid wake time refused");
  chk_cyclic_max: assert property (wr_cyc && cfg_wdata_in > 16'h68b0 |=> cfg_err_out)
    else $error("period above max not refused");
  chk_unjoined_range: assert property (cfg_wr_in && cfg_sel_in == 3'h3 &&
      (cfg_wdata_in == 16'h0000 || cfg_wdata_in > 16'h68b0) |=> cfg_err_out)
    else $error("bad unjoined period not refused");
  chk_idle_mode: assert property ((mode_q == 8'h00) [*3] |-> !asleep_out)
    else $error("asleep in no-sleep mode");
  chk_coord_awake: assert property (is_coordinator_in [*3] |-> !asleep_out)
    else $error("coordinator asleep");
  chk_direct_flag: assert property (wr_cyc && cfg_wdata_in <= 16'h68b0 |->
      ##2 direct_mode_out == ($past(cfg_wdata_in, 2) == 16'h0000))
    else $error("direct flag wrong after period write");
  chk_store_held: assert property (msg_store_in && is_coordinator_in && !direct_mode_out |=> msg_held_out)
    else $error("message not held");
  chk_discard_drop: assert property (msg_discard_out |->
      $past(msg_held_out) && (!msg_held_out || $past(msg_store_in)))
    else $error("discard without held message");
  chk_poll_wake: assert property (poll_req_out |-> !asleep_out && $past(asleep_out) && !$past(opt_q))
    else $error("poll outside wake");
  chk_retry_wake: assert property (assoc_retry_out |-> !asleep_out && $past(asleep_out))
    else $error("retry outside wake");
  cover property (poll_req_out);
  cover property (assoc_retry_out);
  cover property (msg_discard_out);
endmodule
`default_nettype wire

// file: dv/host_cfg_model.sv
`default_nettype none
module host_cfg_model (
  // Clock
  input wire logic clk_in,
  // Answers
  input wire logic [15:0] cfg_rdata_in,
  input wire logic cfg_err_in,
  // Requests
  output logic cfg_wr_out,
  output logic [2:0] cfg_sel_out,
  output logic [15:0] cfg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr_out = 1'b0;
    cfg_sel_out = 3'h0;
    cfg_wdata_out = 16'h0000;
  end
  // Data inverted once released
  task automatic write_cfg(input logic [2:0] sel, input logic [15:0] data, output logic err);
    @(negedge clk_in);
    cfg_wr_out = 1'b1;
    cfg_sel_out = sel;
    cfg_wdata_out = data;
    @(negedge clk_in);
    cfg_wr_out = 1'b0;
    cfg_wdata_out = ~data;
    err = cfg_err_in;
  endtask
  task automatic read_cfg(input logic [2:0] sel, output logic [15:0] data);
    @(negedge clk_in);
    cfg_sel_out = sel;
    @(negedge clk_in);
    data = cfg_rdata_in;
  endtask
endmodule
`default_nettype wire

// file: dv/cyclic_sleep_controller_tb_top.sv
`default_nettype none
module cyclic_sleep_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] sel; logic [15:0] data; logic err; logic [15:0] rb;} row_s;
  logic clk_in, rst_n_in, cfg_wr_in, cfg_err_out, is_coord, assoc_en, assoc, act, pin, store, deliv;
  logic held, discard, direct, asleep, poll, retry, saw_poll, saw_retry, err;
  logic sample, saw_sample, saw_discard;
  logic [2:0] sel;
  logic [15:0] wdata, rdata, rd;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  row_s rows [18] = '{'{3'h0, 16'h0002, 1'b1, 16'h0000}, '{3'h0, 16'h0003, 1'b1, 16'h0000},
    '{3'h0, 16'h0104, 1'b1, 16'h0000}, '{3'h0, 16'h0001, 1'b0, 16'h0001}, '{3'h0, 16'h0004, 1'b0, 16'h0004},
    '{3'h0, 16'h0005, 1'b0, 16'h0005}, '{3'h0, 16'h0000, 1'b0, 16'h0000}, '{3'h1, 16'h0000, 1'b1, 16'h1388},
    '{3'h1, 16'hffff, 1'b0, 16'hffff}, '{3'h1, 16'h0001, 1'b0, 16'h0001}, '{3'h2, 16'h68b1, 1'b1, 16'h0000},
    '{3'h2, 16'h68b0, 1'b0, 16'h68b0}, '{3'h3, 16'h0000, 1'b1, 16'h03e8}, '{3'h3, 16'h68b1, 1'b1, 16'h03e8},
    '{3'h3, 16'h68b0, 1'b0, 16'h68b0}, '{3'h4, 16'h0004, 1'b1, 16'h0000}, '{3'h4, 16'h0003, 1'b0, 16'h0003},
    '{3'h5, 16'h0001, 1'b1, 16'h0000}};
  logic [15:0] rst_vals [5] = '{16'h0000, 16'h1388, 16'h0000, 16'h03e8, 16'h0000};
  cyclic_sleep_controller #(.MS_TICK_CYCLES(4)) cyclic_sleep_controller_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cfg_wr_in(cfg_wr_in), .cfg_sel_in(sel), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .cfg_err_out(cfg_err_out),
    .is_coordinator_in(is_coord), .associate_en_in(assoc_en), .associated_in(assoc), .activity_in(act),
    .sleep_pin_in(pin), .msg_store_in(store), .msg_delivered_in(deliv), .msg_held_out(held),
    .msg_discard_out(discard), .direct_mode_out(direct), .asleep_out(asleep), .poll_req_out(poll),
    .assoc_retry_out(retry), .sample_req_out(sample));
  host_cfg_model host_cfg_model_i (.clk_in(clk_in), .cfg_rdata_in(rdata), .cfg_err_in(cfg_err_out),
    .cfg_wr_out(cfg_wr_in), .cfg_sel_out(sel), .cfg_wdata_out(wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    rst_n_in = 1'b0;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    host_cfg_model_i.write_cfg(s, d, err);
  endtask
  task automatic wait_for(input int k, input logic v, output int cnt);
    cnt = 0;
    while ((k == 0 ? asleep : held) !== v && cnt < 2000) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask
  task automatic pulse(input logic s, input logic d);
    @(negedge clk_in);
    store = s;
    deliv = d;
    @(negedge clk_in);
    store = 1'b0;
    deliv = 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (poll) saw_poll = 1'b1;
    if (retry) saw_retry = 1'b1;
    if (sample) saw_sample = 1'b1;
    if (discard) saw_discard = 1'b1;
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      close_out();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {is_coord, assoc, act, pin, store, deliv, saw_poll, saw_retry, saw_sample, saw_discard} = 10'h100;
    assoc_en = 1'b1;
    do_reset();
    for (int i = 0; i < 18; i++) begin
      host_cfg_model_i.write_cfg(rows[i].sel, rows[i].data, err);
      check(err === rows[i].err, "write status");
      if (rows[i].sel < 3'h5) host_cfg_model_i.read_cfg(rows[i].sel, rd);
      if (rows[i].sel < 3'h5) check(rd === rows[i].rb, "readback");
    end
    $display("done: table");
    do_reset();
    for (int s = 0; s < 5; s++) begin
      host_cfg_model_i.read_cfg(s[2:0], rd);
      check(rd === rst_vals[s], "reset value");
    end
    check(direct === 1'b1, "direct after reset");
    repeat (60) @(negedge clk_in);
    check(asleep === 1'b0, "idle mode asleep");
    wr(3'h0, 16'h0001);
    pin = 1'b1;
    repeat (8) @(negedge clk_in);
    check(asleep === 1'b1, "pin sleep");
    pin = 1'b0;
    $display("done: reset and pin sleep");
    wr(3'h3, 16'h0002);
    wr(3'h1, 16'h0003);
    wr(3'h2, 16'h0001);
    wr(3'h0, 16'h0004);
    saw_poll = 1'b0;
    saw_sample = 1'b0;
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    check(n >= 35 && n <= 46, "sleep length");
    wait_for(0, 1'b1, n);
    check(n >= 8 && n <= 17, "wake length");
    check(saw_poll === 1'b1, "no poll on wake");
    check(saw_sample === 1'b1, "no sample on wake");
    wr(3'h4, 16'h0003);
    saw_poll = 1'b0;
    saw_sample = 1'b0;
    wait_for(0, 1'b0, n);
    repeat (3) @(negedge clk_in);
    check(saw_poll === 1'b0, "poll not disabled");
    check(saw_sample === 1'b0, "sample not suppressed");
    assoc = 1'b0;
    saw_retry = 1'b0;
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    check(n >= 75 && n <= 86, "unjoined sleep length");
    repeat (2) @(negedge clk_in);
    check(saw_retry === 1'b1, "no retry");
    assoc = 1'b1;
    wr(3'h2, 16'h0010);
    wr(3'h0, 16'h0005);
    wait_for(0, 1'b1, n);
    repeat (20) @(negedge clk_in);
    pin = 1'b1;
    wait_for(0, 1'b0, n);
    check(n <= 8, "pin wake late");
    pin = 1'b0;
    act = 1'b1;
    repeat (20) @(negedge clk_in);
    check(asleep === 1'b0, "slept during activity");
    act = 1'b0;
    wait_for(0, 1'b1, n);
    check(n >= 8 && n <= 17, "wake after activity");
    $display("done: cyclic");
    do_reset();
    is_coord = 1'b1;
    wr(3'h2, 16'h0001);
    wr(3'h0, 16'h0004);
    repeat (60) @(negedge clk_in);
    check(asleep === 1'b0, "coordinator slept");
    pulse(1'b1, 1'b0);
    check(held === 1'b1, "not held");
    wait_for(1, 1'b0, n);
    check(n >= 93 && n <= 106, "hold time");
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    check(held === 1'b0, "held after delivery");
    check(saw_discard === 1'b1, "no discard on expiry");
    wr(3'h2, 16'h0000);
    repeat (2) @(negedge clk_in);
    check(direct === 1'b1, "not direct");
    pulse(1'b1, 1'b0);
    check(held === 1'b0, "held in direct mode");
    host_cfg_model_i.read_cfg(3'h5, rd);
    check(rd === 16'h0008, "status word");
    $display("done: coordinator");
    close_out();
  end
endmodule
bind cyclic_sleep_controller cyclic_sleep_controller_properties cyclic_sleep_controller_properties_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in),
  .cfg_wdata_in(cfg_wdata_in), .cfg_err_out(cfg_err_out), .is_coordinator_in(is_coordinator_in),
  .msg_store_in(msg_store_in), .msg_held_out(msg_held_out), .msg_discard_out(msg_discard_out),
  .direct_mode_out(direct_mode_out), .asleep_out(asleep_out), .poll_req_out(poll_req_out),
  .assoc_retry_out(assoc_retry_out));
`default_nettype wire
